// *** shared/quad_counter_regs.vh ***
// Register map and field constants of the quadrature up/down counter
// Function
// - Two counters: inputs one/two, three/four
// - Count both edges, twice the pulses
// - Handle count rates up to 3000 Hz
// - Counter operates only while enabled
// - Clear forces value zero, zero flag follows
// - Load rising edge copies start value
// - Flags follow loaded value at once
// - Upper flag when value at/above upper
// - Lower flag when value at/below lower
// - Zero flag exactly when value is zero
// - Range overflow flags, value holds last
// - Overflow direction sets comparison flags
// - Setpoints and start value signed 32-bit
// - Actual value output continuously, signed
// - Clear acts only in run state
// - Retentive value survives stop; reset clears it
// - Retentive counter resumes on run start
// - Shared input: last counter runs only
`ifndef QUAD_COUNTER_REGS_VH
`define QUAD_COUNTER_REGS_VH

// ----------------------------------------------------------------
// Address map, byte addresses
// ----------------------------------------------------------------
`define QC_CH_STRIDE 8'h20
`define QC_CTRL 8'h00
`define QC_UPPER 8'h04
`define QC_LOWER 8'h08
`define QC_START 8'h0c
`define QC_VALUE 8'h10
`define QC_STATUS 8'h14
`define QC_RUN 8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define QC_EN_BIT 0
`define QC_CLR_BIT 1
`define QC_LOAD_BIT 2
`define QC_RET_BIT 3
`define QC_SEL_BIT 4
`define QC_ST_UPPER 0
`define QC_ST_LOWER 1
`define QC_ST_ZERO 2
`define QC_ST_RANGE 3

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define QC_CTRL_RST 5'h00
`define QC_FLAGS_RST 4'h4
`define QC_WORD_RST 32'h00000000
`define QC_RUN_RST 1'b0
`define QC_RESP_OKAY 2'h0
`define QC_RESP_SLVERR 2'h2

`endif

// *** rtl/quad_counter_channel.v ***
// One quadrature counter instance with saturation and comparison flags
`timescale 1ns/1ps
`default_nettype none
`include "quad_counter_regs.vh"

module quad_counter_channel (
  input wire clk,
  input wire rstn,
  input wire chan_a,
  input wire chan_b,
  input wire run,
  input wire run_start,
  input wire enable,
  input wire clear,
  input wire load,
  input wire retentive,
  input wire [31:0] upper,
  input wire [31:0] lower,
  input wire [31:0] start,
  output reg [31:0] value_reg,
  output reg [3:0] flags_reg
);

  reg a_prev_reg;
  reg load_prev_reg;
  reg range_reg;
  reg neg_reg;
  reg [31:0] value_next;
  reg range_next;
  reg neg_next;
  reg [3:0] flags_next;

  // Both edges of A are counted; B gives the direction
  wire a_edge = chan_a ^ a_prev_reg;
  wire count_up = chan_a ^ chan_b;
  wire step = a_edge & enable & run;
  wire [32:0] step_val = count_up ? 33'h000000001 : 33'h1ffffffff;
  wire [32:0] sum = {value_reg[31], value_reg} + step_val;
  wire ovf = sum[32] ^ sum[31];

  always @* begin
    value_next = value_reg;
    range_next = range_reg;
    neg_next = neg_reg;
    if (clear && run) begin
      value_next = `QC_WORD_RST;
      range_next = 1'b0;
    end else if (load && !load_prev_reg) begin
      value_next = start;
      range_next = 1'b0;
    end else if (run_start && !retentive) begin
      value_next = `QC_WORD_RST;
      range_next = 1'b0;
    end else if (step) begin
      if (ovf) begin
        range_next = 1'b1;
        neg_next = sum[32];
      end else begin
        value_next = sum[31:0];
        range_next = 1'b0;
      end
    end
    if (range_next) begin
      flags_next = neg_next ? 4'h2 : 4'h1;
    end else begin
      flags_next[`QC_ST_UPPER] = $signed(value_next) >= $signed(upper);
      flags_next[`QC_ST_LOWER] = $signed(value_next) <= $signed(lower);
      flags_next[`QC_ST_ZERO] = value_next == `QC_WORD_RST;
      flags_next[`QC_ST_RANGE] = 1'b0;
    end
    flags_next[`QC_ST_RANGE] = range_next;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_prev_reg <= 1'b0;
      load_prev_reg <= 1'b0;
      range_reg <= 1'b0;
      neg_reg <= 1'b0;
      value_reg <= `QC_WORD_RST;
      flags_reg <= `QC_FLAGS_RST;
    end else begin
      a_prev_reg <= chan_a;
      load_prev_reg <= load;
      range_reg <= range_next;
      neg_reg <= neg_next;
      value_reg <= value_next;
      flags_reg <= flags_next;
    end
  end

endmodule // quad_counter_channel
`default_nettype wire

// *** rtl/quadrature_updown_counter.v ***
// Two quadrature counters behind an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "quad_counter_regs.vh"

module quadrature_updown_counter #(
  parameter NUM_CH = 2
) (
  input wire CLK,
  input wire RSTN,
  input wire FIRST_CHANNEL_A_INPUT,
  input wire FIRST_CHANNEL_B_INPUT,
  input wire SECOND_CHANNEL_A_INPUT,
  input wire SECOND_CHANNEL_B_INPUT,
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  output wire [31:0] ACTUAL_VALUE_OUT_0,
  output wire [31:0] ACTUAL_VALUE_OUT_1,
  output wire [1:0] UPPER_REACHED_FLAG,
  output wire [1:0] LOWER_REACHED_FLAG,
  output wire [1:0] ZERO_FLAG,
  output wire [1:0] RANGE_EXCEEDED_FLAG
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam F_CTRL = 3'd0;
  localparam F_UPPER = 3'd1;
  localparam F_LOWER = 3'd2;
  localparam F_START = 3'd3;
  localparam F_VALUE = 3'd4;
  localparam F_STATUS = 3'd5;
  localparam F_RUN = 3'd6;
  localparam F_NONE = 3'd7;

  // Maps a byte address to a field code
  function [2:0] field_of;
    input [7:0] addr;
    begin
      if (addr == `QC_RUN) begin
        field_of = F_RUN;
      end else if (addr[7:6] != 2'h0 || addr[1:0] != 2'h0) begin
        field_of = F_NONE;
      end else begin
        case ({3'h0, addr[4:0]})
          `QC_CTRL: field_of = F_CTRL;
          `QC_UPPER: field_of = F_UPPER;
          `QC_LOWER: field_of = F_LOWER;
          `QC_START: field_of = F_START;
          `QC_VALUE: field_of = F_VALUE;
          `QC_STATUS: field_of = F_STATUS;
          default: field_of = F_NONE;
        endcase
      end
    end
  endfunction

  // Applies byte strobes to a stored word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[8*i +: 8] = data[8*i +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bit order: first A, first B, second A, second B
  reg [3:0] pin_meta_reg;
  reg [3:0] pin_sync_reg;
  wire [3:0] pins = {SECOND_CHANNEL_B_INPUT, SECOND_CHANNEL_A_INPUT,
                     FIRST_CHANNEL_B_INPUT, FIRST_CHANNEL_A_INPUT};

  // Sampling at 250 MHz leaves wide margin over the encoder rate
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= pins;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [4:0] ctrl_reg [0:NUM_CH-1];
  reg [31:0] upper_reg [0:NUM_CH-1];
  reg [31:0] lower_reg [0:NUM_CH-1];
  reg [31:0] start_reg [0:NUM_CH-1];
  reg run_reg;
  reg run_prev_reg;
  wire run_start = run_reg & ~run_prev_reg;
  wire [31:0] value_w [0:NUM_CH-1];
  wire [3:0] flags_w [0:NUM_CH-1];
  wire [NUM_CH-1:0] pair_w;

  // ----------------------------------------------------------------
  // Counter instances
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
      // Each counter uses its own pin pair unless steered to the other
      wire pair = (c == 1) ^ ctrl_reg[c][`QC_SEL_BIT];
      // A later counter that claims the same pair silences this one
      wire claimed_later = (c == 0) && (pair_w[0] == pair_w[1]);
      wire ch_enable = ctrl_reg[c][`QC_EN_BIT] & ~claimed_later;
      assign pair_w[c] = pair;
      quad_counter_channel u_channel (
        .clk(CLK),
        .rstn(RSTN),
        .chan_a(pin_sync_reg[{pair, 1'b0}]),
        .chan_b(pin_sync_reg[{pair, 1'b1}]),
        .run(run_reg),
        .run_start(run_start),
        .enable(ch_enable),
        .clear(ctrl_reg[c][`QC_CLR_BIT]),
        .load(ctrl_reg[c][`QC_LOAD_BIT]),
        .retentive(ctrl_reg[c][`QC_RET_BIT]),
        .upper(upper_reg[c]),
        .lower(lower_reg[c]),
        .start(start_reg[c]),
        .value_reg(value_w[c]),
        .flags_reg(flags_w[c])
      );
      assign UPPER_REACHED_FLAG[c] = flags_w[c][`QC_ST_UPPER];
      assign LOWER_REACHED_FLAG[c] = flags_w[c][`QC_ST_LOWER];
      assign ZERO_FLAG[c] = flags_w[c][`QC_ST_ZERO];
      assign RANGE_EXCEEDED_FLAG[c] = flags_w[c][`QC_ST_RANGE];
    end
  endgenerate

  assign ACTUAL_VALUE_OUT_0 = value_w[0];
  assign ACTUAL_VALUE_OUT_1 = value_w[1];

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  reg aw_have_reg;
  reg w_have_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire do_write = aw_have_reg & w_have_reg;
  wire [2:0] w_field = field_of(aw_addr_reg);
  wire w_ch = aw_addr_reg[5];
  wire [31:0] ctrl_merged = merge({27'h0, ctrl_reg[w_ch]}, w_data_reg, w_strb_reg);
  integer k;

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `QC_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= `QC_WORD_RST;
      w_strb_reg <= 4'h0;
      run_reg <= `QC_RUN_RST;
      run_prev_reg <= `QC_RUN_RST;
      for (k = 0; k < NUM_CH; k = k + 1) begin
        ctrl_reg[k] <= `QC_CTRL_RST;
        upper_reg[k] <= `QC_WORD_RST;
        lower_reg[k] <= `QC_WORD_RST;
        start_reg[k] <= `QC_WORD_RST;
      end
    end else begin
      run_prev_reg <= run_reg;
      AWREADY <= !aw_have_reg && !BVALID;
      WREADY <= !w_have_reg && !BVALID;
      if (AWREADY && AWVALID) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WREADY && WVALID) begin
        w_have_reg <= 1'b1;
        w_data_reg <= WDATA;
        w_strb_reg <= WSTRB;
        WREADY <= 1'b0;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        AWREADY <= 1'b0;
        WREADY <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= (w_field == F_NONE) ? `QC_RESP_SLVERR : `QC_RESP_OKAY;
        case (w_field)
          F_CTRL: ctrl_reg[w_ch] <= ctrl_merged[4:0];
          F_UPPER: upper_reg[w_ch] <= merge(upper_reg[w_ch], w_data_reg, w_strb_reg);
          F_LOWER: lower_reg[w_ch] <= merge(lower_reg[w_ch], w_data_reg, w_strb_reg);
          F_START: start_reg[w_ch] <= merge(start_reg[w_ch], w_data_reg, w_strb_reg);
          F_RUN: begin
            if (w_strb_reg[0]) begin
              run_reg <= w_data_reg[0];
            end
          end
          default: begin
          end
        endcase
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  wire [2:0] r_field = field_of(ARADDR);
  wire r_ch = ARADDR[5];
  reg [31:0] read_word;

  always @* begin
    case (r_field)
      F_CTRL: read_word = {27'h0, ctrl_reg[r_ch]};
      F_UPPER: read_word = upper_reg[r_ch];
      F_LOWER: read_word = lower_reg[r_ch];
      F_START: read_word = start_reg[r_ch];
      F_VALUE: read_word = value_w[r_ch];
      F_STATUS: read_word = {28'h0, flags_w[r_ch]};
      F_RUN: read_word = {31'h0, run_reg};
      default: read_word = `QC_WORD_RST;
    endcase
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= `QC_WORD_RST;
      RRESP <= `QC_RESP_OKAY;
    end else begin
      ARREADY <= !RVALID;
      if (ARREADY && ARVALID) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RDATA <= read_word;
        RRESP <= (r_field == F_NONE) ? `QC_RESP_SLVERR : `QC_RESP_OKAY;
      end
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b0;
      end
    end
  end

endmodule // quadrature_updown_counter
`default_nettype wire

// *** dv/quadrature_updown_counter_asserts.sv ***
// Port-level checker of flags, saturation and register-bus timing
`timescale 1ns/1ps
`default_nettype none
`include "quad_counter_regs.vh"
module quad_counter_checker (
  input wire CLK,
  input wire RSTN,
  input wire AWVALID,
  input wire AWREADY,
  input wire WVALID,
  input wire WREADY,
  input wire BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  input wire ARREADY,
  input wire RVALID,
  input wire [31:0] RDATA,
  input wire [1:0] RRESP,
  input wire [31:0] ACTUAL_VALUE_OUT_0,
  input wire [1:0] UPPER_REACHED_FLAG,
  input wire [1:0] LOWER_REACHED_FLAG,
  input wire [1:0] ZERO_FLAG,
  input wire [1:0] RANGE_EXCEEDED_FLAG
);
  localparam logic [31:0] MAXV = 32'h7fffffff;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  zero_match_a: assert property (ZERO_FLAG[0] == (ACTUAL_VALUE_OUT_0 == 32'h0))
    else $error("zero flag disagrees with value");
  range_limit_a: assert property (RANGE_EXCEEDED_FLAG[0] |->
    (ACTUAL_VALUE_OUT_0 == MAXV || ACTUAL_VALUE_OUT_0 == ~MAXV)) else $error("range without limit");
  range_stable_a: assert property (RANGE_EXCEEDED_FLAG[0] && $past(RANGE_EXCEEDED_FLAG[0])
    |-> $stable(ACTUAL_VALUE_OUT_0)) else $error("value moved while out of range");
  range_pos_a: assert property (RANGE_EXCEEDED_FLAG[0] && ACTUAL_VALUE_OUT_0 == MAXV
    |-> UPPER_REACHED_FLAG[0] && !LOWER_REACHED_FLAG[0] && !ZERO_FLAG[0]) else $error("pos flags");
  range_neg_a: assert property (RANGE_EXCEEDED_FLAG[0] && ACTUAL_VALUE_OUT_0 == ~MAXV
    |-> LOWER_REACHED_FLAG[0] && !UPPER_REACHED_FLAG[0]) else $error("neg flags");
  wr_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write response late");
  rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID) else $error("read data late");
  rd_error_a: assert property (ARVALID && ARREADY && ARADDR == 8'h18
    |=> RRESP == `QC_RESP_SLVERR && RDATA == 32'h0) else $error("unmapped read not refused");
  aw_block_a: assert property (BVALID |-> !AWREADY && !WREADY) else $error("write taken early");
  ar_block_a: assert property (RVALID |-> !ARREADY) else $error("read taken early");
  cover property (RANGE_EXCEEDED_FLAG[0] && ACTUAL_VALUE_OUT_0 == MAXV);
  cover property (RANGE_EXCEEDED_FLAG[0] && ACTUAL_VALUE_OUT_0 == ~MAXV);
  cover property (BVALID && BREADY);
endmodule // quad_counter_checker
bind quadrature_updown_counter quad_counter_checker u_chk (.CLK, .RSTN, .AWVALID, .AWREADY,
  .WVALID, .WREADY, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RVALID, .RDATA, .RRESP,
  .ACTUAL_VALUE_OUT_0, .UPPER_REACHED_FLAG, .LOWER_REACHED_FLAG, .ZERO_FLAG,
  .RANGE_EXCEEDED_FLAG);
`default_nettype wire

// *** dv/quad_encoder_model.sv ***
// Behavioural quadrature encoder driving one channel pair
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model #(
  parameter int QTR_NS = 83333
) (
  output logic a,
  output logic b
);
  int ph = 0;
  // Gray order 00,10,11,01 with A leading when turning up
  assign a = (ph == 1) || (ph == 2);
  assign b = (ph >= 2);
  // Equal quarter periods keep mark and space alike
  task automatic turn(input int n, input bit dir);
    repeat (n) begin
      #(QTR_NS);
      ph = dir ? (ph + 1) % 4 : (ph + 3) % 4;
    end
  endtask
endmodule // quad_encoder_model
`default_nettype wire

// *** dv/quadrature_updown_counter_bench.sv ***
// Self-checking bench of the two-channel quadrature counter
`timescale 1ns/1ps
`default_nettype none
`include "quad_counter_regs.vh"
module quadrature_updown_counter_bench;
  logic CLK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [7:0] AWADDR, ARADDR, bs;
  logic [31:0] WDATA, rd_d;
  logic [31:0] ev [2], up [2], lo [2];
  logic rg [2];
  logic [1:0] rd_r, wr_r;
  logic [3:0] WSTRB, ws;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, e0a, e0b, e1a, e1b;
  wire [1:0] BRESP, RRESP, UPPER_REACHED_FLAG, LOWER_REACHED_FLAG, ZERO_FLAG, RANGE_EXCEEDED_FLAG;
  wire [31:0] RDATA, ACTUAL_VALUE_OUT_0, ACTUAL_VALUE_OUT_1;
  int err_count = 0, compares = 0, cyc = 0, n;
  quadrature_updown_counter u_dut (.CLK, .RSTN, .FIRST_CHANNEL_A_INPUT(e0a),
    .FIRST_CHANNEL_B_INPUT(e0b), .SECOND_CHANNEL_A_INPUT(e1a), .SECOND_CHANNEL_B_INPUT(e1b),
    .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
    .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .ACTUAL_VALUE_OUT_0, .ACTUAL_VALUE_OUT_1, .UPPER_REACHED_FLAG, .LOWER_REACHED_FLAG,
    .ZERO_FLAG, .RANGE_EXCEEDED_FLAG);
  // Quarter period shortened far below the rate limit to keep the run short
  quad_encoder_model #(.QTR_NS(42)) u_enc0 (.a(e0a), .b(e0b));
  quad_encoder_model #(.QTR_NS(42)) u_enc1 (.a(e1a), .b(e1b));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // ----------------------------------------
  // Bus and checking tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge CLK);
    AWADDR <= ad;
    WDATA <= d;
    WSTRB <= ws;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (AWVALID || WVALID);
    do @(posedge CLK); while (!BVALID);
    wr_r = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge CLK);
    ARADDR <= ad;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge CLK); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (!RVALID);
    rd_d = RDATA;
    rd_r = RRESP;
    RREADY <= 1'b0;
  endtask
  function automatic logic [3:0] st_exp(input int c);
    return {rg[c], ev[c] == 0, $signed(ev[c]) <= $signed(lo[c]), $signed(ev[c]) >= $signed(up[c])};
  endfunction
  task automatic look(input int c);
    repeat (8) @(posedge CLK);
    chk(c ? ACTUAL_VALUE_OUT_1 : ACTUAL_VALUE_OUT_0, ev[c]);
    chk({RANGE_EXCEEDED_FLAG[c], ZERO_FLAG[c], LOWER_REACHED_FLAG[c], UPPER_REACHED_FLAG[c]},
      st_exp(c));
    rd(8'(c) * `QC_CH_STRIDE + `QC_STATUS);
    chk(rd_d, {28'h0, st_exp(c)});
    rd(8'(c) * `QC_CH_STRIDE + `QC_VALUE);
    chk(rd_d, ev[c]);
  endtask
  task automatic spin(input int c, input int k, input bit dir);
    if (c == 0) u_enc0.turn(k, dir);
    else u_enc1.turn(k, dir);
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    RSTN = 1'b0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, ARADDR, WDATA} = 48'h0;
    {WSTRB, ws} = 8'hff;
    void'($urandom(73));
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    chk(ZERO_FLAG, 2'b11);
    rd(8'h18);
    chk(rd_r, `QC_RESP_SLVERR);
    chk(rd_d, 32'h0);
    wr(8'h1c, 32'h5);
    chk(wr_r, `QC_RESP_SLVERR);
    wr(`QC_RUN, 32'h1);
    for (int c = 0; c < 2; c++) begin
      bs = 8'(c) * `QC_CH_STRIDE;
      rd(bs + `QC_CTRL);
      chk(rd_d, 32'h0);
      {ev[c], rg[c]} = 33'h0;
      up[c] = $urandom_range(9, 3);
      lo[c] = $urandom_range(4) - 2;
      wr(bs + `QC_UPPER, up[c]);
      // Only lane 0 written: upper lanes must keep their bytes
      ws = 4'h1;
      wr(bs + `QC_UPPER, 32'hffffff00 | up[c]);
      ws = 4'hf;
      rd(bs + `QC_UPPER);
      chk(rd_d, up[c]);
      // Value is read-only: write answered but ignored
      wr(bs + `QC_VALUE, 32'h1234);
      chk(wr_r, `QC_RESP_OKAY);
      wr(bs + `QC_LOWER, lo[c]);
      wr(bs + `QC_CTRL, 32'h1);
      // Whole cycles leave channel A low, so a later pair swap sees no false edge
      n = 4 * $urandom_range(4, 1);
      spin(c, n, 1'b1);
      ev[c] += n / 2;
      look(c);
      spin(c, 2 * n, 1'b0);
      ev[c] -= n;
      look(c);
      wr(bs + `QC_CTRL, 32'h0);
      spin(c, 4, 1'b1);
      look(c);
      wr(bs + `QC_START, 32'h7ffffffe);
      wr(bs + `QC_CTRL, 32'h5);
      ev[c] = 32'h7ffffffe;
      look(c);
      spin(c, 6, 1'b1);
      {ev[c], rg[c]} = {32'h7fffffff, 1'b1};
      look(c);
      wr(bs + `QC_CTRL, 32'h1);
      wr(bs + `QC_START, 32'h80000001);
      wr(bs + `QC_CTRL, 32'h5);
      {ev[c], rg[c]} = {32'h80000001, 1'b0};
      look(c);
      spin(c, 6, 1'b0);
      {ev[c], rg[c]} = {32'h80000000, 1'b1};
      look(c);
      wr(bs + `QC_CTRL, 32'h1);
      wr(bs + `QC_CTRL, 32'h7);
      {ev[c], rg[c]} = 33'h0;
      look(c);
      wr(`QC_RUN, 32'h0);
      wr(bs + `QC_CTRL, 32'h1);
      wr(bs + `QC_START, 32'h5);
      wr(bs + `QC_CTRL, 32'h5);
      wr(bs + `QC_CTRL, 32'h3);
      ev[c] = 32'h5;
      look(c);
      wr(bs + `QC_CTRL, 32'h9);
      wr(`QC_RUN, 32'h1);
      look(c);
      wr(`QC_RUN, 32'h0);
      wr(bs + `QC_CTRL, 32'h1);
      wr(`QC_RUN, 32'h1);
      ev[c] = 32'h0;
      look(c);
    end
    wr(`QC_CH_STRIDE, 32'h11);
    spin(0, 4, 1'b1);
    ev[1] += 2;
    look(0);
    look(1);
    tally_and_finish;
  end
endmodule // quadrature_updown_counter_bench
`default_nettype wire
